// ### include/mmbd_pkg.sv
// shared constants, types and helpers for the memory map decoder
package mmbd_pkg;

  // ---------------------------------------------------------------
  // region bounds (inclusive byte addresses)
  // ---------------------------------------------------------------
  localparam logic [31:0] CODE_LAST     = 32'h1FFF_FFFF;
  localparam logic [31:0] BOOT_BASE     = 32'h0000_0000;
  localparam logic [31:0] BOOT_LAST     = 32'h0000_03FF;
  localparam logic [31:0] FLASH_BASE    = 32'h1000_0000;
  localparam logic [31:0] FLASH_LAST    = 32'h102F_FFFF;
  localparam logic [31:0] INFO_BASE     = 32'h1080_0000;
  localparam logic [31:0] INFO_LAST     = 32'h1080_3FFF;
  localparam logic [31:0] XF_BASE       = 32'h0800_0000;
  localparam logic [31:0] XF_LAST       = 32'h0FFF_FFFF;
  localparam logic [31:0] SRAM_RGN_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_RGN_LAST = 32'h3FFF_FFFF;
  localparam logic [31:0] SRAM_BASE     = 32'h2000_0000;
  localparam logic [31:0] SRAM_LAST     = 32'h200F_FFFF;
  localparam logic [31:0] ALIAS_BASE    = 32'h2200_0000;
  localparam logic [31:0] ALIAS_LAST    = 32'h23FF_FFFF;
  localparam logic [31:0] DDR_BASE      = 32'h6000_0000;
  localparam logic [31:0] DDR_LAST      = 32'h7FFF_FFFF;
  localparam logic [31:0] XR_BASE       = 32'h8000_0000;
  localparam logic [31:0] XR_LAST       = 32'h9FFF_FFFF;

  // ---------------------------------------------------------------
  // alias offset fields and access sizes
  // ---------------------------------------------------------------
  localparam int BB_IDX_LO  = 2;
  localparam int BB_IDX_HI  = 6;
  localparam int BB_WORD_LO = 7;
  localparam int BB_WORD_HI = 24;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TGT_NONE  = 3'h0,
    TGT_FLASH = 3'h1,
    TGT_INFO  = 3'h2,
    TGT_XF    = 3'h3,
    TGT_XR    = 3'h4,
    TGT_DDR   = 3'h5,
    TGT_SRAM  = 3'h6
  } mmbd_target_e;

  typedef enum logic [1:0] {
    PATH_IBUS = 2'h0,
    PATH_DBUS = 2'h1,
    PATH_SBUS = 2'h2
  } mmbd_path_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_MEM   = 5'h02,
    ST_BB_RD = 5'h04,
    ST_BB_WR = 5'h08,
    ST_RESP  = 5'h10
  } mmbd_state_e;

  typedef struct packed {
    logic        valid;
    mmbd_path_e  path;
    logic        core;
    logic        fetch;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mmbd_req_s;

  typedef struct packed {
    logic         valid;
    mmbd_target_e target;
    logic         cacheable;
    logic         write;
    logic [1:0]   size;
    logic [31:0]  addr;
    logic [31:0]  wdata;
  } mmbd_mem_s;

  typedef struct packed {
    logic        done;
    logic        error;
    logic [31:0] rdata;
  } mmbd_rsp_s;

  typedef struct packed {
    mmbd_target_e target;
    logic [31:0]  offset;
    logic         bitband;
    logic [4:0]   bit_idx;
    logic         cacheable;
    logic         error;
  } mmbd_dec_s;

  function automatic logic mmbd_in_rng(input logic [31:0] a,
                                       input logic [31:0] lo,
                                       input logic [31:0] hi);
    mmbd_in_rng = (a >= lo) && (a <= hi);
  endfunction : mmbd_in_rng

endpackage : mmbd_pkg

// ### rtl/mmbd_decoder.sv
// memory map decoder with sram bit-band alias translation
`timescale 1ns/1ps
module mmbd_decoder
  import mmbd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        xf_en,
  input  wire logic        xr_en,
  input  wire logic        ddr_en,
  input  wire mmbd_req_s   req,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output mmbd_mem_s        mem,
  output mmbd_rsp_s        rsp
);

  // ---------------------------------------------------------------
  // region decode
  // ---------------------------------------------------------------
  mmbd_dec_s dec;

  mmbd_region_decode u_decode (
    .req    (req),
    .xf_en  (xf_en),
    .xr_en  (xr_en),
    .ddr_en (ddr_en),
    .dec    (dec)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mmbd_state_e state;
  mmbd_state_e next_state;
  mmbd_mem_s   next_mem;
  mmbd_rsp_s   next_rsp;
  logic [4:0]  bb_idx;
  logic [4:0]  next_bb_idx;
  logic        bb_write;
  logic        next_bb_write;
  logic        bb_set;
  logic        next_bb_set;
  logic [31:0] bb_mask;
  logic [31:0] bb_word;

  // ---------------------------------------------------------------
  // bit-band helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] mmbd_bit_mask(input logic [4:0] idx);
    mmbd_bit_mask = 32'h0000_0001 << idx;
  endfunction : mmbd_bit_mask

  always_comb begin
    bb_mask = mmbd_bit_mask(bb_idx);
    // only the addressed bit changes; the rest are written back as read
    if (bb_set) begin
      bb_word = mem_rdata | bb_mask;
    end else begin
      bb_word = mem_rdata & ~bb_mask;
    end
  end

  // ---------------------------------------------------------------
  // sequencer: next values
  // ---------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_mem      = mem;
    next_rsp      = rsp;
    next_bb_idx   = bb_idx;
    next_bb_write = bb_write;
    next_bb_set   = bb_set;
    next_rsp.done = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (req.valid) begin
          if (dec.error) begin
            // the master sees a fault instead of data
            next_rsp.done  = 1'b1;
            next_rsp.error = 1'b1;
            next_rsp.rdata = 32'h0000_0000;
            next_state     = ST_RESP;
          end else if (dec.bitband) begin
            // first step of a core alias access is one word read
            next_mem.valid     = 1'b1;
            next_mem.target    = TGT_SRAM;
            next_mem.cacheable = 1'b0;
            next_mem.write     = 1'b0;
            next_mem.size      = SIZE_WORD;
            next_mem.addr      = dec.offset;
            next_mem.wdata     = 32'h0000_0000;
            next_bb_idx        = dec.bit_idx;
            next_bb_write      = req.write;
            next_bb_set        = req.wdata[0];
            next_state         = ST_BB_RD;
          end else begin
            next_mem.valid     = 1'b1;
            next_mem.target    = dec.target;
            next_mem.cacheable = dec.cacheable;
            next_mem.write     = req.write;
            next_mem.size      = req.size;
            next_mem.addr      = dec.offset;
            next_mem.wdata     = req.wdata;
            next_state         = ST_MEM;
          end
        end
      end
      ST_MEM: begin
        if (mem_ack) begin
          next_mem.valid = 1'b0;
          next_rsp.done  = 1'b1;
          next_rsp.error = 1'b0;
          next_rsp.rdata = mem_rdata;
          next_state     = ST_RESP;
        end
      end
      ST_BB_RD: begin
        if (mem_ack) begin
          if (bb_write) begin
            // keep the same word address, turn the read into a write
            next_mem.write = 1'b1;
            next_mem.wdata = bb_word;
            next_state     = ST_BB_WR;
          end else begin
            next_mem.valid = 1'b0;
            next_rsp.done  = 1'b1;
            next_rsp.error = 1'b0;
            next_rsp.rdata = {31'h0000_0000, mem_rdata[bb_idx]};
            next_state     = ST_RESP;
          end
        end
      end
      ST_BB_WR: begin
        if (mem_ack) begin
          next_mem.valid = 1'b0;
          next_mem.write = 1'b0;
          next_rsp.done  = 1'b1;
          next_rsp.error = 1'b0;
          next_rsp.rdata = 32'h0000_0000;
          next_state     = ST_RESP;
        end
      end
      ST_RESP: begin
        // one dead cycle lets the master drop valid after done
        next_state = ST_IDLE;
      end
      default: begin
        next_state    = ST_IDLE;
        next_mem      = '0;
        next_rsp      = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer: registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      mem      <= '0;
      rsp      <= '0;
      bb_idx   <= 5'h00;
      bb_write <= 1'b0;
      bb_set   <= 1'b0;
    end else begin
      state    <= next_state;
      mem      <= next_mem;
      rsp      <= next_rsp;
      bb_idx   <= next_bb_idx;
      bb_write <= next_bb_write;
      bb_set   <= next_bb_set;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = (state == ST_IDLE) && req.valid;

  sequence seq_bb_start;
    take && dec.bitband;
  endsequence

  sequence seq_bb_read_back;
    state == ST_BB_RD && mem_ack;
  endsequence

  sequence seq_bb_write_back;
    state == ST_BB_WR && mem_ack;
  endsequence

  unmapped_err_a: assert property (
    take && !mmbd_in_rng(req.addr, BOOT_BASE, BOOT_LAST)
      && !mmbd_in_rng(req.addr, FLASH_BASE, FLASH_LAST)
      && !mmbd_in_rng(req.addr, INFO_BASE, INFO_LAST)
      && !mmbd_in_rng(req.addr, SRAM_BASE, SRAM_LAST)
      && !mmbd_in_rng(req.addr, ALIAS_BASE, ALIAS_LAST)
      && !(xf_en && mmbd_in_rng(req.addr, XF_BASE, XF_LAST))
      && !(xr_en && mmbd_in_rng(req.addr, XR_BASE, XR_LAST))
      && !(ddr_en && mmbd_in_rng(req.addr, DDR_BASE, DDR_LAST))
    |=> rsp.done && rsp.error && !mem.valid)
    else $error("unmapped access did not fault");

  alias_foreign_a: assert property (
    take && !req.core && mmbd_in_rng(req.addr, ALIAS_BASE, ALIAS_LAST)
    |=> rsp.done && rsp.error)
    else $error("non-core alias access not refused");

  info_readonly_a: assert property (
    take && req.write && mmbd_in_rng(req.addr, INFO_BASE, INFO_LAST)
    |=> rsp.error && !mem.valid)
    else $error("write to info block accepted");

  xf_readonly_a: assert property (
    take && req.write && mmbd_in_rng(req.addr, XF_BASE, XF_LAST)
    |=> rsp.error && !mem.valid)
    else $error("write to serial flash window accepted");

  flash_route_a: assert property (
    take && !req.write && req.path == PATH_DBUS && !req.fetch
      && mmbd_in_rng(req.addr, FLASH_BASE, FLASH_LAST)
    |=> mem.valid && mem.target == TGT_FLASH
      && mem.addr == $past(req.addr) - FLASH_BASE)
    else $error("flash read misrouted");

  boot_vector_a: assert property (
    take && req.path == PATH_IBUS && req.fetch && !req.write
      && req.addr == BOOT_BASE
    |=> mem.valid && mem.target == TGT_FLASH && mem.addr == BOOT_BASE)
    else $error("reset vector fetch not served from flash");

  sram_nocache_a: assert property (
    mem.valid && mem.target == TGT_SRAM |-> !mem.cacheable)
    else $error("sram access marked cacheable");

  dma_sram_a: assert property (
    take && !req.core && req.write && req.size <= SIZE_WORD
      && req.path == PATH_SBUS
      && mmbd_in_rng(req.addr, SRAM_BASE, SRAM_LAST)
    |=> mem.valid && mem.write && mem.target == TGT_SRAM)
    else $error("bus master sram write not forwarded");

  bb_addr_a: assert property (
    seq_bb_start
    |=> mem.valid && !mem.write && mem.size == SIZE_WORD
      && mem.addr[1:0] == 2'h0 && state == ST_BB_RD)
    else $error("alias read not word aligned");

  bb_read_a: assert property (
    (seq_bb_read_back and !bb_write)
    |=> rsp.done && !rsp.error && rsp.rdata[31:1] == 31'h0000_0000
      && rsp.rdata[0] == $past(mem_rdata[bb_idx]))
    else $error("alias read returned wrong bit");

  bb_rmw_a: assert property (
    (seq_bb_read_back and bb_write)
    |=> mem.valid && mem.write && mem.addr == $past(mem.addr)
      && ((mem.wdata >> $past(bb_idx)) & 32'h0000_0001)
         == {31'h0000_0000, $past(bb_set)}
      && ((mem.wdata & ~$past(bb_mask)) == ($past(mem_rdata) & ~$past(bb_mask))))
    else $error("alias write changed more than one bit");

  resp_pulse_a: assert property (
    rsp.done |=> !rsp.done ##1 state == ST_IDLE)
    else $error("response held longer than one cycle");

  code_path_a: assert property (
    take && mmbd_in_rng(req.addr, BOOT_BASE, CODE_LAST)
      && ((req.path == PATH_IBUS && !req.fetch)
      || (req.path == PATH_DBUS && req.fetch))
    |=> rsp.done && rsp.error && !mem.valid)
    else $error("code access on wrong core bus accepted");

  boot_write_a: assert property (
    take && req.write && mmbd_in_rng(req.addr, BOOT_BASE, BOOT_LAST)
    |=> rsp.error && !mem.valid)
    else $error("write to vector alias accepted");

  info_route_a: assert property (
    take && !req.write && req.path == PATH_DBUS && !req.fetch
      && mmbd_in_rng(req.addr, INFO_BASE, INFO_LAST)
    |=> mem.valid && mem.target == TGT_INFO
      && mem.addr == $past(req.addr) - INFO_BASE)
    else $error("info block read misrouted");

  xf_fetch_a: assert property (
    take && xf_en && req.path == PATH_IBUS && req.fetch && !req.write
      && mmbd_in_rng(req.addr, XF_BASE, XF_LAST)
    |=> mem.valid && mem.target == TGT_XF && mem.cacheable
      && mem.addr == $past(req.addr) - XF_BASE)
    else $error("serial flash fetch misrouted");

  xr_route_a: assert property (
    take && xr_en && req.path == PATH_SBUS
      && mmbd_in_rng(req.addr, XR_BASE, XR_LAST)
    |=> mem.valid && mem.target == TGT_XR && mem.write == $past(req.write)
      && mem.addr == $past(req.addr) - XR_BASE)
    else $error("serial ram access misrouted");

  ddr_route_a: assert property (
    take && ddr_en && req.path == PATH_SBUS
      && mmbd_in_rng(req.addr, DDR_BASE, DDR_LAST)
    |=> mem.valid && mem.target == TGT_DDR && !mem.cacheable
      && mem.addr == $past(req.addr) - DDR_BASE)
    else $error("ddr window access misrouted");

  sram_access_a: assert property (
    take && req.path == PATH_SBUS && req.size <= SIZE_WORD
      && mmbd_in_rng(req.addr, SRAM_BASE, SRAM_LAST)
    |=> mem.valid && mem.target == TGT_SRAM && mem.size == $past(req.size)
      && mem.addr == $past(req.addr) - SRAM_BASE)
    else $error("sram access misrouted");

  sram_size_a: assert property (
    take && req.size > SIZE_WORD
      && mmbd_in_rng(req.addr, SRAM_BASE, SRAM_LAST)
    |=> rsp.done && rsp.error && !mem.valid)
    else $error("sram access of illegal size accepted");

  sram_fetch_a: assert property (
    take && req.path == PATH_SBUS && req.fetch && req.size <= SIZE_WORD
      && mmbd_in_rng(req.addr, SRAM_BASE, SRAM_LAST)
    |=> mem.valid && mem.target == TGT_SRAM && !mem.cacheable)
    else $error("sram fetch not sent uncached over system bus");

  mem_read_a: assert property (
    state == ST_MEM && mem_ack
    |=> rsp.done && !rsp.error && !mem.valid && rsp.rdata == $past(mem_rdata))
    else $error("target data not returned");

  bb_done_a: assert property (
    seq_bb_write_back
    |=> rsp.done && !rsp.error && !mem.valid && state == ST_RESP)
    else $error("alias write did not finish after its write");

  mem_hold_a: assert property (
    mem.valid && !mem_ack |=> $stable(mem))
    else $error("target request changed before acknowledge");

endmodule : mmbd_decoder

// ### rtl/mmbd_region_decode.sv
// combinational region decode of one bus request
`timescale 1ns/1ps
module mmbd_region_decode
  import mmbd_pkg::*;
(
  input  wire mmbd_req_s req,
  input  wire logic      xf_en,
  input  wire logic      xr_en,
  input  wire logic      ddr_en,
  output mmbd_dec_s      dec
);

  logic        code;
  logic        path_ok;
  logic [31:0] aoff;

  always_comb begin
    aoff = req.addr - ALIAS_BASE;
    dec  = '0;
    code = mmbd_in_rng(req.addr, BOOT_BASE, CODE_LAST);
    // code space is fed by the system bus and two core buses, one per access kind
    if (code) begin
      path_ok = (req.path == PATH_SBUS) ||
                (req.path == PATH_IBUS && req.fetch) ||
                (req.path == PATH_DBUS && !req.fetch);
    end else begin
      path_ok = (req.path == PATH_SBUS);
    end
    if (!path_ok) begin
      dec.error = 1'b1;
    end else if (mmbd_in_rng(req.addr, BOOT_BASE, BOOT_LAST)) begin
      dec.target = TGT_FLASH;
      dec.offset = req.addr;
      dec.error  = req.write;
    end else if (mmbd_in_rng(req.addr, FLASH_BASE, FLASH_LAST)) begin
      dec.target = TGT_FLASH;
      dec.offset = req.addr - FLASH_BASE;
    end else if (mmbd_in_rng(req.addr, INFO_BASE, INFO_LAST)) begin
      dec.target = TGT_INFO;
      dec.offset = req.addr - INFO_BASE;
      dec.error  = req.write;
    end else if (xf_en && mmbd_in_rng(req.addr, XF_BASE, XF_LAST)) begin
      dec.target = TGT_XF;
      dec.offset = req.addr - XF_BASE;
      dec.error  = req.write;
    end else if (mmbd_in_rng(req.addr, SRAM_BASE, SRAM_LAST)) begin
      dec.target = TGT_SRAM;
      dec.offset = req.addr - SRAM_BASE;
      dec.error  = (req.size > SIZE_WORD);
    end else if (mmbd_in_rng(req.addr, ALIAS_BASE, ALIAS_LAST)) begin
      // translation exists only for the core; others fault
      dec.target  = TGT_SRAM;
      dec.offset  = {12'h000, aoff[BB_WORD_HI:BB_WORD_LO], 2'h0};
      dec.bit_idx = aoff[BB_IDX_HI:BB_IDX_LO];
      dec.bitband = req.core;
      dec.error   = !req.core;
    end else if (ddr_en && mmbd_in_rng(req.addr, DDR_BASE, DDR_LAST)) begin
      dec.target = TGT_DDR;
      dec.offset = req.addr - DDR_BASE;
    end else if (xr_en && mmbd_in_rng(req.addr, XR_BASE, XR_LAST)) begin
      dec.target = TGT_XR;
      dec.offset = req.addr - XR_BASE;
    end else begin
      dec.error = 1'b1;
    end
    if (dec.error) begin
      dec.target  = TGT_NONE;
      dec.bitband = 1'b0;
    end
    // only flash-backed fetches go through a cache; sram never does
    dec.cacheable = req.fetch &&
                    (dec.target == TGT_FLASH || dec.target == TGT_XF);
  end

endmodule : mmbd_region_decode

// ### test/mmbd_decoder_tb.sv
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
module mmbd_decoder_tb import mmbd_pkg::*;;
  logic        ref_clk, rst_n, xf_en, xr_en, ddr_en, mem_ack, r_err;
  logic        m_cache;
  logic [31:0] mem_rdata, r_rdata, m_addr, m_wdata;
  logic [3:0]  lat;
  logic [2:0]  m_tgt;
  logic [1:0]  m_size;
  mmbd_req_s   req;
  mmbd_mem_s   mem;
  mmbd_rsp_s   rsp;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          m_n;

  mmbd_decoder dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .xf_en(xf_en),
    .xr_en(xr_en), .ddr_en(ddr_en), .req(req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem(mem), .rsp(rsp));
  mmbd_mem_model model_u (.ref_clk(ref_clk), .rst_n(rst_n), .lat(lat),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ---------------------------------------------------------------
  // compare, transfer and verdict tasks
  // ---------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %b", $time, m, got);
    end
  endtask : check_bit

  // cfw = {core, fetch, write}; valid drops the edge after done
  task automatic xfer(input mmbd_path_e p, input logic [2:0] cfw,
                      input logic [1:0] s, input logic [31:0] a, d);
    m_n = 0;
    m_tgt = 3'h7;
    @(posedge ref_clk);
    req <= '{1'b1, p, cfw[2], cfw[1], cfw[0], s, a, d};
    for (int i = 0; i < 60; i++) begin
      @(negedge ref_clk);
      if (mem.valid && m_tgt === 3'h7) begin
        m_tgt = mem.target;
        m_addr = mem.addr;
        m_cache = mem.cacheable;
        m_size = mem.size;
      end
      if (mem.valid && mem.write) m_wdata = mem.wdata;
      if (mem_ack) m_n++;
      if (rsp.done) break;
    end
    check_bit(rsp.done, 1'b1, "no response");
    r_err = rsp.error;
    r_rdata = rsp.rdata;
    @(posedge ref_clk);
    req <= '0;
    @(posedge ref_clk);
  endtask : xfer

  task automatic ok(input mmbd_path_e p, input logic [2:0] cfw,
                    input logic [31:0] a, d, input mmbd_target_e t,
                    input logic [31:0] off, input logic ca,
                    input logic [1:0] s = SIZE_WORD);
    xfer(p, cfw, s, a, d);
    check_bit(r_err, 1'b0, "error");
    check_word({29'h0, m_tgt}, {29'h0, t}, "target");
    check_word(m_addr, off, "offset");
    check_bit(m_cache, ca, "cacheable");
  endtask : ok

  task automatic err(input mmbd_path_e p, input logic [2:0] cfw,
                     input logic [31:0] a);
    xfer(p, cfw, SIZE_WORD, a, 32'h0);
    check_bit(r_err, 1'b1, "no error");
    check_word(r_rdata, 32'h0, "error data");
    check_word(m_n, 32'h0, "mem touched");
  endtask : err

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_code();
    ok(PATH_SBUS, 3'b101, 32'h1000_0000, 32'h1000_0000, TGT_FLASH, 0, 0);
    ok(PATH_IBUS, 3'b110, 32'h0, 0, TGT_FLASH, 32'h0, 1'b1);
    check_word(r_rdata, 32'h1000_0000, "vector");
    err(PATH_SBUS, 3'b101, 32'h0000_0000);
    ok(PATH_DBUS, 3'b100, 32'h102F_FFFC, 0, TGT_FLASH, 32'h2F_FFFC, 0);
    ok(PATH_IBUS, 3'b110, 32'h1000_0008, 0, TGT_FLASH, 32'h8, 1'b1);
    err(PATH_IBUS, 3'b100, 32'h1000_0000);
    err(PATH_DBUS, 3'b110, 32'h1000_0000);
    err(PATH_DBUS, 3'b100, 32'h1030_0000);
    err(PATH_DBUS, 3'b100, 32'h0000_0400);
    ok(PATH_DBUS, 3'b100, 32'h1080_3FFC, 0, TGT_INFO, 32'h3FFC, 0);
    err(PATH_SBUS, 3'b101, 32'h1080_0000);
    err(PATH_DBUS, 3'b100, 32'h1080_4000);
    err(PATH_SBUS, 3'b000, 32'hA000_0000);
    err(PATH_SBUS, 3'b000, 32'hFFFF_FFFC);
    $display("code test done");
  endtask : t_code

  task automatic t_windows();
    err(PATH_DBUS, 3'b100, 32'h0800_0000);
    err(PATH_SBUS, 3'b000, 32'h8000_0000);
    err(PATH_SBUS, 3'b110, 32'h6000_0000);
    @(posedge ref_clk);
    {xf_en, xr_en, ddr_en} <= 3'h7;
    ok(PATH_DBUS, 3'b100, 32'h0FFF_FFFC, 0, TGT_XF, 32'h07FF_FFFC, 0);
    ok(PATH_IBUS, 3'b110, 32'h0800_0010, 0, TGT_XF, 32'h10, 1'b1);
    err(PATH_SBUS, 3'b101, 32'h0800_0000);
    ok(PATH_SBUS, 3'b001, 32'h9FFF_FFFC, 5, TGT_XR, 32'h1FFF_FFFC, 0);
    ok(PATH_SBUS, 3'b110, 32'h6000_0000, 0, TGT_DDR, 32'h0, 0);
    ok(PATH_SBUS, 3'b000, 32'h7FFF_FFFC, 0, TGT_DDR, 32'h1FFF_FFFC, 0);
    $display("window test done");
  endtask : t_windows

  task automatic t_sram();
    @(posedge ref_clk);
    lat <= 4'h3;
    ok(PATH_SBUS, 3'b001, 32'h200F_FFFC, 32'hA5A5_0F0F, TGT_SRAM,
       32'h000F_FFFC, 0);
    check_word(m_wdata, 32'hA5A5_0F0F, "wdata");
    ok(PATH_SBUS, 3'b000, 32'h200F_FFFC, 0, TGT_SRAM, 32'hF_FFFC, 0);
    check_word(r_rdata, 32'hA5A5_0F0F, "rdata");
    ok(PATH_SBUS, 3'b101, 32'h2000_0003, 0, TGT_SRAM, 3, 0, SIZE_BYTE);
    check_word({30'h0, m_size}, {30'h0, SIZE_BYTE}, "size");
    ok(PATH_SBUS, 3'b100, 32'h2000_0002, 0, TGT_SRAM, 2, 0, SIZE_HALF);
    check_word({30'h0, m_size}, {30'h0, SIZE_HALF}, "size");
    ok(PATH_SBUS, 3'b110, 32'h2000_0100, 0, TGT_SRAM, 32'h100, 0);
    err(PATH_SBUS, 3'b100, 32'h2010_0000);
    xfer(PATH_SBUS, 3'b100, 2'h3, 32'h2000_0000, 32'h0);
    check_bit(r_err, 1'b1, "bad size");
    $display("sram test done");
  endtask : t_sram

  // sram word 3 seeded with 0xF0; alias word = base + 3*128 + bit*4
  task automatic t_alias();
    ok(PATH_SBUS, 3'b101, 32'h2000_000C, 32'hF0, TGT_SRAM, 32'hC, 0);
    ok(PATH_SBUS, 3'b101, 32'h2200_0184, 1, TGT_SRAM, 32'hC, 0);
    check_word(m_n, 32'h2, "rmw count");
    check_word(m_wdata, 32'hF2, "set bit");
    ok(PATH_SBUS, 3'b101, 32'h2200_0190, 0, TGT_SRAM, 32'hC, 0);
    check_word(m_wdata, 32'hE2, "clear bit");
    ok(PATH_SBUS, 3'b100, 32'h2200_0184, 0, TGT_SRAM, 32'hC, 0);
    check_word(r_rdata, 32'h1, "bit read");
    check_word(m_n, 32'h1, "read count");
    ok(PATH_SBUS, 3'b100, 32'h2200_0190, 0, TGT_SRAM, 32'hC, 0);
    check_word(r_rdata, 32'h0, "bit read");
    ok(PATH_SBUS, 3'b100, 32'h23FF_FFFC, 0, TGT_SRAM, 32'hF_FFFC, 0);
    check_word(r_rdata, 32'h1, "top bit");
    err(PATH_SBUS, 3'b000, 32'h2200_0184);
    err(PATH_SBUS, 3'b001, 32'h2200_0184);
    $display("alias test done");
  endtask : t_alias

  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // tests need a few hundred cycles; the limit leaves wide margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      print_verdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    {xf_en, xr_en, ddr_en} = 3'h0;
    req = '0;
    lat = 4'h0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_code();
    t_windows();
    t_sram();
    t_alias();
    print_verdict();
  end
endmodule : mmbd_decoder_tb

// ### test/mmbd_mem_model.sv
// memory target model on the decoder's mem side
`timescale 1ns/1ps
module mmbd_mem_model
  import mmbd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] lat,
  input  wire mmbd_mem_s  mem,
  output logic            mem_ack,
  output logic [31:0]     mem_rdata
);
  // ---------------------------------------------------------------
  // word store keyed by target and word address
  // ---------------------------------------------------------------
  logic [31:0] store [logic [32:0]];
  logic [3:0]  cnt;
  logic [32:0] key;
  assign key = {mem.target, mem.addr[31:2]};

  // rdata toggles while idle so a stale sample never looks right
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack   <= 1'b0;
      cnt       <= 4'h0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem.valid && !mem_ack) begin
        if (cnt == lat) begin
          mem_ack <= 1'b1;
          cnt     <= 4'h0;
          if (mem.write) begin
            store[key] = mem.wdata;
          end
          mem_rdata <= store.exists(key) ? store[key] : 32'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule : mmbd_mem_model
